// ==== hdl/irq_priority_and_sources.sv ====
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
// What this block does
// - Only the highest-priority simultaneous request is acknowledged
// - Same level: oldest first, then fixed order
// - Reset, NMI, watchdog, peripheral, step, match order
// - Software interrupts always branch, no arbitration
// - Six external inputs with sense and polarity
// - Both-edge bit makes edge inputs trigger both
// - NMI falling edge is never suppressed
// - NMI pin level readable at port bit 5
// - Key falling edge requests and wakes
// - Held-low key pin masks other key edges
// - Key disable blocks requests and input path
// - Four enabled program-address comparators
// - Address match ignores enable flag and level
// - Address match fires only at instruction start
// - Sequencer vector read clears accepted request; maskable ones only at VEC_MASKABLE or VEC_FAST
// - Clean reset, maskable interrupts held off until software sets the enable flag
// - Acknowledge of a maskable, NMI or watchdog request loads processor level with accepted level
module irq_priority_and_sources #(
  parameter int N_EXT = 6,
  parameter int N_KEY = 4,
  parameter int N_AM = 4,
  parameter int AGE_W = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire irq_pkg::bus_req_t bus,
  output logic [irq_pkg::DATA_W-1:0] rdata,
  input wire logic [N_EXT-1:0] ext_request_input,
  input wire logic unmaskable_pin,
  input wire logic [N_KEY-1:0] key_input_pins,
  input wire logic [N_KEY-1:0] key_dir_in,
  input wire logic wdt_req,
  input wire logic sstep_req,
  input wire logic insn_start,
  input wire logic [irq_pkg::PC_W-1:0] pc,
  input wire logic seq_vec_rd,
  input wire logic [irq_pkg::PC_W-1:0] seq_vec_addr,
  input wire logic sw_int,
  output irq_pkg::accept_t acc,
  output logic sw_branch,
  output logic key_wake,
  output logic [N_KEY-1:0] key_port_level
);
  localparam int NP = N_EXT + 1 + N_KEY;
  localparam int NMI_IX = N_EXT;
  localparam int NS = N_EXT + 1;

  if (N_EXT != 6 || N_KEY != 4 || N_AM != 4 || AGE_W < 2) begin : g_chk
    $error("irq_priority_and_sources: unsupported parameters");
  end

  // ---------------------------------------------------------------
  // Pin conditioning
  // ---------------------------------------------------------------
  logic [NP-1:0] pins, s1, s2, s3, pf, pf_q, rise, fall;
  assign pins = {key_input_pins, unmaskable_pin, ext_request_input};
  assign rise = pf & ~pf_q;
  assign fall = ~pf & pf_q;

  for (genvar g = 0; g < NP; g++) begin : g_pin
    always_ff @(posedge mclk) begin
      s1[g] <= pins[g];
      s2[g] <= s1[g];
      s3[g] <= s2[g];
      // Idle-high reset keeps a pulled-up pin from faking an edge
      if (rst) begin
        pf[g] <= 1'b1;
        pf_q[g] <= 1'b1;
      end else begin
        if (s2[g] == s3[g]) begin
          pf[g] <= s3[g];
        end
        pf_q[g] <= pf[g];
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [irq_pkg::LVL_W-1:0] lvl [NS];
  logic [N_EXT-1:0] pol, lsense, both;
  logic [NS-1:0] req;
  logic key_dis, i_flag;
  logic [irq_pkg::LVL_W-1:0] processor_priority_level;
  logic [N_AM-1:0] am_en, am_pend;
  logic [irq_pkg::PC_W-1:0] am_addr [N_AM];
  logic nmi_pend, wdt_pend, ss_pend;
  logic take, vec_hit;
  logic [NS-1:0] set_ev;

  assign take = seq_vec_rd && acc.valid;
  // Apart from a control write, only the sequencer's vector fetch clears; bus reads never do
  assign vec_hit = take && (seq_vec_addr == irq_pkg::VEC_MASKABLE ||
                            seq_vec_addr == irq_pkg::VEC_FAST);

  function automatic logic [irq_pkg::ADDR_W-1:0] am_off(input int i, input int b);
    am_off = irq_pkg::AM_ADDR_BASE + irq_pkg::ADDR_W'(4 * i + b);
  endfunction

  for (genvar i = 0; i < NS; i++) begin : g_ctl
    logic wr_ctl;
    assign wr_ctl = bus.wr &&
      bus.addr == irq_pkg::EXT_CTL_BASE + irq_pkg::ADDR_W'(i);
    always_ff @(posedge mclk) begin
      if (rst) begin
        lvl[i] <= '0;
        req[i] <= 1'b0;
      end else begin
        if (wr_ctl) begin
          lvl[i] <= bus.wdata[irq_pkg::LVL_W-1:0];
        end
        // An event in the clearing cycle survives
        if (set_ev[i]) begin
          req[i] <= 1'b1;
        end else if (wr_ctl) begin
          req[i] <= bus.wdata[irq_pkg::CTL_REQ];
        end else if (vec_hit && acc.num == irq_pkg::NUM_W'(i)) begin
          req[i] <= 1'b0;
        end
      end
    end
    if (i < N_EXT) begin : g_ext
      always_ff @(posedge mclk) begin
        if (rst) begin
          pol[i] <= 1'b0;
          lsense[i] <= 1'b0;
        end else if (wr_ctl) begin
          pol[i] <= bus.wdata[irq_pkg::CTL_POL];
          lsense[i] <= bus.wdata[irq_pkg::CTL_LSENSE];
        end
      end
      // Level sense re-raises while the active level stands
      assign set_ev[i] = lsense[i] ? (pf[i] == pol[i]) :
        both[i] ? (rise[i] | fall[i]) :
        (pol[i] ? rise[i] : fall[i]);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      both <= '0;
      key_dis <= 1'b0;
      am_en <= '0;
    end else if (bus.wr) begin
      if (bus.addr == irq_pkg::REQ_SEL) begin
        both <= bus.wdata[N_EXT-1:0];
      end
      if (bus.addr == irq_pkg::KEY_DIS) begin
        key_dis <= bus.wdata[irq_pkg::KEY_DIS_BIT];
      end
      if (bus.addr == irq_pkg::AM_EN) begin
        am_en <= bus.wdata[N_AM-1:0];
      end
    end
  end

  for (genvar i = 0; i < N_AM; i++) begin : g_amr
    for (genvar b = 0; b < irq_pkg::PC_W / irq_pkg::DATA_W; b++) begin : g_byte
      always_ff @(posedge mclk) begin
        if (rst) begin
          am_addr[i][irq_pkg::DATA_W*b+:irq_pkg::DATA_W] <= '0;
        end else if (bus.wr && bus.addr == am_off(i, b)) begin
          am_addr[i][irq_pkg::DATA_W*b+:irq_pkg::DATA_W] <= bus.wdata;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Key inputs
  // ---------------------------------------------------------------
  logic [N_KEY-1:0] key_en, key_f;
  logic key_all, key_all_q;
  assign key_f = pf[NP-1:NMI_IX+1];
  assign key_en = key_dir_in & ~{N_KEY{key_dis}};
  // AND of enabled pins: one held low hides the others' edges
  assign key_all = &(key_f | ~key_en);
  assign set_ev[NS-1] = key_all_q & ~key_all;

  always_ff @(posedge mclk) begin
    if (rst) begin
      key_all_q <= 1'b1;
      key_wake <= 1'b0;
      key_port_level <= '0;
    end else begin
      key_all_q <= key_all;
      key_wake <= set_ev[NS-1];
      key_port_level <= key_f & key_en;
    end
  end

  // ---------------------------------------------------------------
  // Fixed sources
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      nmi_pend <= 1'b0;
      wdt_pend <= 1'b0;
      ss_pend <= 1'b0;
      am_pend <= '0;
    end else begin
      // No enable gates this path
      if (fall[NMI_IX]) begin
        nmi_pend <= 1'b1;
      end else if (take && acc.num == irq_pkg::SRC_NMI) begin
        nmi_pend <= 1'b0;
      end
      if (wdt_req) begin
        wdt_pend <= 1'b1;
      end else if (take && acc.num == irq_pkg::SRC_WDT) begin
        wdt_pend <= 1'b0;
      end
      if (sstep_req) begin
        ss_pend <= 1'b1;
      end else if (take && acc.num == irq_pkg::SRC_SSTEP) begin
        ss_pend <= 1'b0;
      end
      for (int i = 0; i < N_AM; i++) begin
        if (insn_start && am_en[i] && pc == am_addr[i]) begin
          am_pend[i] <= 1'b1;
        end else if (take && acc.num == irq_pkg::SRC_AM0 + irq_pkg::NUM_W'(i)) begin
          am_pend[i] <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Arbitration
  // ---------------------------------------------------------------
  logic [AGE_W-1:0] age [NS];
  logic [NS-1:0] elig;
  logic found;
  logic [irq_pkg::NUM_W-1:0] bn;
  logic [irq_pkg::LVL_W-1:0] bl;
  logic [AGE_W-1:0] ba;
  irq_pkg::accept_t next_acc;

  for (genvar i = 0; i < NS; i++) begin : g_age
    assign elig[i] = req[i] && i_flag && lvl[i] > processor_priority_level;
    always_ff @(posedge mclk) begin
      if (rst || !req[i]) begin
        age[i] <= '0;
      end else if (age[i] != '1) begin
        age[i] <= age[i] + AGE_W'(1);
      end
    end
  end

  always_comb begin
    found = 1'b0;
    bn = '0;
    bl = '0;
    ba = '0;
    // Strict compare keeps the lower index on a full tie
    for (int i = 0; i < NS; i++) begin
      if (elig[i] && (!found || lvl[i] > bl ||
          (lvl[i] == bl && age[i] > ba))) begin
        found = 1'b1;
        bn = irq_pkg::NUM_W'(i);
        bl = lvl[i];
        ba = age[i];
      end
    end
    next_acc = '0;
    if (nmi_pend) begin
      next_acc = {1'b1, irq_pkg::SRC_NMI, irq_pkg::LEVEL_FIXED};
    end else if (wdt_pend) begin
      next_acc = {1'b1, irq_pkg::SRC_WDT, irq_pkg::LEVEL_FIXED};
    end else if (found) begin
      next_acc = {1'b1, bn, bl};
    end else if (ss_pend) begin
      next_acc = {1'b1, irq_pkg::SRC_SSTEP, processor_priority_level};
    end else begin
      // Address match skips the enable and level gates
      for (int i = N_AM - 1; i >= 0; i--) begin
        if (am_pend[i]) begin
          next_acc = {1'b1, irq_pkg::SRC_AM0 + irq_pkg::NUM_W'(i), processor_priority_level};
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      acc <= '0;
      sw_branch <= 1'b0;
    end else begin
      acc <= next_acc;
      sw_branch <= sw_int;
    end
  end

  // ---------------------------------------------------------------
  // Processor level, enable flag and read port
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      processor_priority_level <= irq_pkg::LEVEL_RESET;
      i_flag <= 1'b0;
    end else if (take) begin
      i_flag <= 1'b0;
      if (acc.num <= irq_pkg::SRC_WDT) begin
        processor_priority_level <= acc.lvl;
      end
    end else if (bus.wr && bus.addr == irq_pkg::CPU_STAT) begin
      processor_priority_level <= bus.wdata[irq_pkg::LVL_W-1:0];
      i_flag <= bus.wdata[irq_pkg::STAT_IFLAG];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= '0;
      if (bus.rd) begin
        for (int i = 0; i < NS; i++) begin
          if (bus.addr == irq_pkg::EXT_CTL_BASE + irq_pkg::ADDR_W'(i)) begin
            rdata[irq_pkg::LVL_W-1:0] <= lvl[i];
            rdata[irq_pkg::CTL_REQ] <= req[i];
            if (i < N_EXT) begin
              rdata[irq_pkg::CTL_POL] <= pol[i];
              rdata[irq_pkg::CTL_LSENSE] <= lsense[i];
            end
          end
        end
        for (int i = 0; i < N_AM; i++) begin
          for (int b = 0; b < irq_pkg::PC_W / irq_pkg::DATA_W; b++) begin
            if (bus.addr == am_off(i, b)) begin
              rdata <= am_addr[i][irq_pkg::DATA_W*b+:irq_pkg::DATA_W];
            end
          end
        end
        case (bus.addr)
          irq_pkg::REQ_SEL: rdata[N_EXT-1:0] <= both;
          irq_pkg::KEY_DIS: rdata[irq_pkg::KEY_DIS_BIT] <= key_dis;
          irq_pkg::AM_EN: rdata[N_AM-1:0] <= am_en;
          irq_pkg::CPU_STAT: rdata <= {4'h0, i_flag, processor_priority_level};
          irq_pkg::NMI_PORT: rdata[irq_pkg::NMI_PORT_BIT] <= pf[NMI_IX];
          default: ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  property p_nmi_first;
    nmi_pend |=> acc.valid && acc.num == irq_pkg::SRC_NMI;
  endproperty
  a_nmi_first: assert property (p_nmi_first) else $error("nmi lost arbitration");

  property p_wdt_order;
    !nmi_pend && wdt_pend |=> acc.num == irq_pkg::SRC_WDT;
  endproperty
  a_wdt_order: assert property (p_wdt_order) else $error("watchdog out of order");

  sequence s_nmi_fall;
    $fell(pf[NMI_IX]);
  endsequence
  property p_nmi_edge;
    s_nmi_fall |=> nmi_pend;
  endproperty
  a_nmi_edge: assert property (p_nmi_edge) else $error("nmi edge missed");

  property p_port;
    bus.rd && bus.addr == irq_pkg::NMI_PORT
      |=> rdata[irq_pkg::NMI_PORT_BIT] == $past(pf[NMI_IX]);
  endproperty
  a_port: assert property (p_port) else $error("nmi port bit wrong");

  property p_key_dis;
    key_dis |-> !set_ev[NS-1] ##1 !key_wake;
  endproperty
  a_key_dis: assert property (p_key_dis) else $error("key event while disabled");

  property p_level_load;
    take && acc.num <= irq_pkg::SRC_WDT |=> processor_priority_level == $past(acc.lvl);
  endproperty
  a_level_load: assert property (p_level_load) else $error("level not loaded");

  property p_sw;
    sw_int |=> sw_branch;
  endproperty
  a_sw: assert property (p_sw) else $error("software interrupt dropped");

  property p_gate;
    acc.valid && acc.num <= irq_pkg::SRC_KEY
      |-> $past(i_flag) && acc.lvl > $past(processor_priority_level);
  endproperty
  a_gate: assert property (p_gate) else $error("maskable passed gate");

  property p_am_start;
    !insn_start && am_pend == '0 |=> am_pend == '0;
  endproperty
  a_am_start: assert property (p_am_start) else $error("match off boundary");
endmodule

// ==== hdl/irq_pkg.sv ====
package irq_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int PC_W = 24;
  localparam int LVL_W = 3;
  localparam int NUM_W = 4;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] AM_EN = 12'h009;
  localparam logic [ADDR_W-1:0] AM_ADDR_BASE = 12'h010;
  localparam logic [ADDR_W-1:0] EXT_CTL_BASE = 12'h048;
  localparam logic [ADDR_W-1:0] KEY_CTL = 12'h04E;
  localparam logic [ADDR_W-1:0] CPU_STAT = 12'h0F0;
  localparam logic [ADDR_W-1:0] REQ_SEL = 12'h31F;
  localparam logic [ADDR_W-1:0] KEY_DIS = 12'h3AF;
  localparam logic [ADDR_W-1:0] NMI_PORT = 12'h3C4;

  // ---------------------------------------------------------------
  // Field positions and fixed values
  // ---------------------------------------------------------------
  localparam int CTL_REQ = 3;
  localparam int CTL_POL = 4;
  localparam int CTL_LSENSE = 5;
  localparam int STAT_IFLAG = 3;
  localparam int KEY_DIS_BIT = 7;
  localparam int NMI_PORT_BIT = 5;
  localparam logic [LVL_W-1:0] LEVEL_RESET = 3'h0;
  localparam logic [LVL_W-1:0] LEVEL_FIXED = 3'h7;
  localparam logic [PC_W-1:0] VEC_MASKABLE = 24'h000000;
  localparam logic [PC_W-1:0] VEC_FAST = 24'h000002;

  // Source numbers seen by the sequencer
  localparam logic [NUM_W-1:0] SRC_KEY = 4'h6;
  localparam logic [NUM_W-1:0] SRC_NMI = 4'h7;
  localparam logic [NUM_W-1:0] SRC_WDT = 4'h8;
  localparam logic [NUM_W-1:0] SRC_SSTEP = 4'h9;
  localparam logic [NUM_W-1:0] SRC_AM0 = 4'hA;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic valid;
    logic [NUM_W-1:0] num;
    logic [LVL_W-1:0] lvl;
  } accept_t;
endpackage

// ==== test/irq_far_side.sv ====
`timescale 1ns/1ns
module irq_far_side (
  input wire logic mclk,
  input wire irq_pkg::accept_t acc,
  output logic unmaskable_pin,
  output logic seq_vec_rd,
  output logic [irq_pkg::PC_W-1:0] seq_vec_addr
);
  // The pin is pulled up when nobody drives it; the idle address bus shows
  // the inverse of the last address so stale values never look valid
  initial begin
    unmaskable_pin = 1'b1;
    seq_vec_rd = 1'b0;
    seq_vec_addr = 24'hA5A5A5;
  end

  task automatic pulse_nmi(input int low_cycles);
    @(posedge mclk);
    unmaskable_pin <= 1'b0;
    repeat (low_cycles) @(posedge mclk);
    unmaskable_pin <= 1'b1;
  endtask

  // One vector read, only while a winner is on offer; delay gives a slow sequencer
  task automatic ack(input logic [irq_pkg::PC_W-1:0] addr, input int delay);
    repeat (delay) @(posedge mclk);
    if (acc.valid === 1'b1) begin
      @(posedge mclk);
      seq_vec_rd <= 1'b1;
      seq_vec_addr <= addr;
      @(posedge mclk);
      seq_vec_rd <= 1'b0;
      seq_vec_addr <= ~addr;
    end
  endtask
endmodule

// ==== test/test_irq_priority_and_sources.sv ====
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("ERROR at %0t: got %h expected %h", $time, (a), (e)); end end
module test_irq_priority_and_sources;
  logic mclk;
  logic rst;
  irq_pkg::bus_req_t bus;
  logic [7:0] rdata;
  logic [5:0] ext;
  logic unmaskable_pin;
  logic [3:0] keys;
  logic [3:0] key_dir;
  logic wdt_req;
  logic sstep_req;
  logic insn_start;
  logic [23:0] pc;
  logic seq_vec_rd;
  logic [23:0] seq_vec_addr;
  logic sw_int;
  irq_pkg::accept_t acc;
  logic sw_branch;
  logic key_wake;
  logic [3:0] key_level;
  logic [7:0] d;
  int n_mismatch;
  int total_checks;

  irq_priority_and_sources DUT (.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata),
    .ext_request_input(ext), .unmaskable_pin(unmaskable_pin), .key_input_pins(keys),
    .key_dir_in(key_dir), .wdt_req(wdt_req), .sstep_req(sstep_req),
    .insn_start(insn_start), .pc(pc), .seq_vec_rd(seq_vec_rd),
    .seq_vec_addr(seq_vec_addr), .sw_int(sw_int), .acc(acc), .sw_branch(sw_branch),
    .key_wake(key_wake), .key_port_level(key_level));

  irq_far_side far (.mclk(mclk), .acc(acc), .unmaskable_pin(unmaskable_pin),
    .seq_vec_rd(seq_vec_rd), .seq_vec_addr(seq_vec_addr));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge mclk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge mclk);
    bus <= '0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge mclk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    bus <= '0;
    #1 v = rdata;
  endtask

  // Bounded wait for a winner, then compare its number and level
  task automatic wait_acc(input logic [3:0] num, input logic [2:0] lvl);
    int i;
    // Skip the cycle in which an acknowledged winner is still on offer
    @(posedge mclk);
    #1;
    for (i = 0; i < 30 && acc.valid !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    if (acc.valid !== 1'b1) begin
      n_mismatch++;
      $display("ERROR at %0t: no request accepted in time", $time);
      finish_test();
    end
    `CHK(acc.num, num)
    `CHK(acc.lvl, lvl)
  endtask

  task automatic no_acc(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1 `CHK(acc.valid, 1'b0)
    end
  endtask

  task automatic quiet_keys(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1 `CHK(key_wake, 1'b0)
    end
  endtask

  task automatic wait_wake();
    int i;
    for (i = 0; i < 12 && key_wake !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    `CHK(key_wake, 1'b1)
    if (key_wake !== 1'b1) begin
      finish_test();
    end
  endtask

  initial begin
    rst = 1'b1;
    bus = '0;
    ext = 6'h3F;
    keys = 4'hF;
    key_dir = 4'hF;
    wdt_req = 1'b0;
    sstep_req = 1'b0;
    insn_start = 1'b0;
    pc = 24'h000000;
    sw_int = 1'b0;
    n_mismatch = 0;
    total_checks = 0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd(irq_pkg::CPU_STAT, d);
    `CHK(d, 8'h00)
    rd(12'h7FF, d);
    `CHK(d, 8'h00)
    no_acc(6);
    $display("test reset done");

    fork
      far.pulse_nmi(8);
      begin
        repeat (7) @(posedge mclk);
        rd(irq_pkg::NMI_PORT, d);
        `CHK(d[5], 1'b0)
      end
    join
    wait_acc(irq_pkg::SRC_NMI, 3'h7);
    far.ack(irq_pkg::VEC_FAST, 2);
    rd(irq_pkg::CPU_STAT, d);
    `CHK(d, 8'h07)
    rd(irq_pkg::NMI_PORT, d);
    `CHK(d[5], 1'b1)
    no_acc(4);
    $display("test nmi done");

    wr(irq_pkg::EXT_CTL_BASE, 8'h04);
    wr(irq_pkg::EXT_CTL_BASE + 12'h001, 8'h04);
    wr(irq_pkg::CPU_STAT, 8'h08);
    @(posedge mclk);
    ext <= 6'h3C;
    wait_acc(4'h0, 3'h4);
    far.ack(irq_pkg::VEC_MASKABLE, 0);
    no_acc(4);
    rd(irq_pkg::CPU_STAT, d);
    `CHK(d, 8'h04)
    rd(irq_pkg::EXT_CTL_BASE, d);
    `CHK(d[3], 1'b0)
    wr(irq_pkg::CPU_STAT, 8'h08);
    wait_acc(4'h1, 3'h4);
    far.ack(24'h000100, 1);
    rd(irq_pkg::EXT_CTL_BASE + 12'h001, d);
    `CHK(d[3], 1'b1)
    wr(irq_pkg::EXT_CTL_BASE + 12'h001, 8'h04);
    wr(irq_pkg::CPU_STAT, 8'h0C);
    @(posedge mclk);
    ext <= 6'h3F;
    repeat (8) @(posedge mclk);
    ext <= 6'h3E;
    no_acc(10);
    rd(irq_pkg::EXT_CTL_BASE, d);
    `CHK(d[3], 1'b1)
    wr(irq_pkg::EXT_CTL_BASE, 8'h04);
    $display("test peripheral done");

    wr(irq_pkg::CPU_STAT, 8'h00);
    @(posedge mclk);
    wdt_req <= 1'b1;
    sstep_req <= 1'b1;
    @(posedge mclk);
    wdt_req <= 1'b0;
    sstep_req <= 1'b0;
    wait_acc(irq_pkg::SRC_WDT, 3'h7);
    far.ack(irq_pkg::VEC_MASKABLE, 0);
    wait_acc(irq_pkg::SRC_SSTEP, 3'h7);
    far.ack(irq_pkg::VEC_MASKABLE, 0);
    no_acc(3);
    $display("test fixed order done");

    wr(irq_pkg::AM_ADDR_BASE, 8'h34);
    wr(irq_pkg::AM_ADDR_BASE + 12'h001, 8'h12);
    wr(irq_pkg::AM_ADDR_BASE + 12'h002, 8'h00);
    wr(irq_pkg::AM_EN, 8'h01);
    @(posedge mclk);
    pc <= 24'h001234;
    no_acc(6);
    @(posedge mclk);
    insn_start <= 1'b1;
    @(posedge mclk);
    insn_start <= 1'b0;
    wait_acc(irq_pkg::SRC_AM0, 3'h7);
    far.ack(irq_pkg::VEC_MASKABLE, 0);
    pc <= 24'h000000;
    $display("test address match done");

    @(posedge mclk);
    sw_int <= 1'b1;
    @(posedge mclk);
    sw_int <= 1'b0;
    #1 `CHK(sw_branch, 1'b1)
    $display("test software interrupt done");

    repeat (6) @(posedge mclk);
    `CHK(key_level, 4'hF)
    keys <= 4'hE;
    wait_wake();
    rd(irq_pkg::KEY_CTL, d);
    `CHK(d[3], 1'b1)
    @(posedge mclk);
    keys <= 4'hC;
    quiet_keys(10);
    keys <= 4'hF;
    wr(irq_pkg::KEY_DIS, 8'h80);
    repeat (6) @(posedge mclk);
    keys <= 4'hB;
    quiet_keys(10);
    `CHK(key_level, 4'h0)
    $display("test key done");

    wr(irq_pkg::REQ_SEL, 8'h04);
    wr(irq_pkg::EXT_CTL_BASE + 12'h002, 8'h00);
    @(posedge mclk);
    ext <= 6'h3B;
    repeat (8) @(posedge mclk);
    rd(irq_pkg::EXT_CTL_BASE + 12'h002, d);
    `CHK(d[3], 1'b1)
    wr(irq_pkg::EXT_CTL_BASE + 12'h002, 8'h00);
    @(posedge mclk);
    ext <= 6'h3F;
    repeat (8) @(posedge mclk);
    rd(irq_pkg::EXT_CTL_BASE + 12'h002, d);
    `CHK(d[3], 1'b1)
    $display("test both edges done");

    wr(irq_pkg::REQ_SEL, 8'h00);
    wr(irq_pkg::EXT_CTL_BASE + 12'h003, 8'h20);
    @(posedge mclk);
    ext <= 6'h37;
    repeat (8) @(posedge mclk);
    // A clear while the low level stands must not stick
    wr(irq_pkg::EXT_CTL_BASE + 12'h003, 8'h20);
    rd(irq_pkg::EXT_CTL_BASE + 12'h003, d);
    `CHK(d[3], 1'b1)
    @(posedge mclk);
    ext <= 6'h3F;
    repeat (8) @(posedge mclk);
    wr(irq_pkg::EXT_CTL_BASE + 12'h003, 8'h20);
    rd(irq_pkg::EXT_CTL_BASE + 12'h003, d);
    `CHK(d[3], 1'b0)
    $display("test level sense done");
    finish_test();
  end
endmodule
